// [hw/touch_pkg.sv]
// Overview of operation
// - All link timing is counted from the one system clock, so every serial clock quarter is a fixed cycle count.
// - While the reset input is high every state register returns to its idle value.
// - The valid output falls when a read starts and rises only one cycle after the six results are loaded.
// - The horizontal coordinate of each of the two points is a 10-bit output of its own.
// - The vertical coordinate of each of the two points is a 9-bit output of its own.
// - The touch count is a 2-bit output that only ever shows zero, one or two.
// - The gesture is an 8-bit output loaded in the same cycle as the coordinates.
// - Only the defined gesture codes are passed on, and anything else is shown as the no-gesture code.
// - The reader is the serial bus controller: it drives the clock, shares the data line and decodes the bytes.
package touch_pkg;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_MHZ = 200;
  localparam int BIT_TIME_NS  = 10000;
  localparam int QTR_CYC      = (BIT_TIME_NS * CLK_FREQ_MHZ) / (1000 * 4);

  // ==========================================================
  // result widths
  localparam int X_W    = 10;
  localparam int Y_W    = 9;
  localparam int CNT_W  = 2;
  localparam int GEST_W = 8;

  // ==========================================================
  // touch controller read layout
  localparam logic [7:0] REG_FIRST  = 8'h00;
  localparam int         READ_LEN   = 10;
  localparam int         B_GESTURE  = 0;
  localparam int         B_COUNT    = 1;
  localparam int         B_X1_HI    = 2;
  localparam int         B_X1_LO    = 3;
  localparam int         B_Y1_HI    = 4;
  localparam int         B_Y1_LO    = 5;
  localparam int         B_X2_HI    = 6;
  localparam int         B_X2_LO    = 7;
  localparam int         B_Y2_HI    = 8;
  localparam int         B_Y2_LO    = 9;
  localparam logic [1:0] COUNT_MAX  = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [X_W-1:0]    X_RST    = 10'h000;
  localparam logic [Y_W-1:0]    Y_RST    = 9'h000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;

  // ==========================================================
  // gesture codes
  localparam logic [7:0] G_NONE      = 8'h00;
  localparam logic [7:0] G_MOVE_MASK = 8'hF1;
  localparam logic [7:0] G_MOVE1     = 8'h10;
  localparam logic [7:0] G_MOVE2     = 8'h30;
  localparam logic [7:0] G_ROT_CW    = 8'h28;
  localparam logic [7:0] G_ROT_ACW   = 8'h29;
  localparam logic [7:0] G_CLICK1    = 8'h20;
  localparam logic [7:0] G_DCLICK1   = 8'h22;
  localparam logic [7:0] G_CLICK2    = 8'h40;
  localparam logic [7:0] G_ZOOM_IN   = 8'h48;
  localparam logic [7:0] G_ZOOM_OUT  = 8'h49;

  // ==========================================================
  // byte engine operations
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } op_t;

  function automatic logic gesture_known(input logic [7:0] g);
    return ((g & G_MOVE_MASK) == G_MOVE1) || ((g & G_MOVE_MASK) == G_MOVE2) ||
           (g == G_ROT_CW) || (g == G_ROT_ACW) || (g == G_CLICK1) || (g == G_DCLICK1) ||
           (g == G_CLICK2) || (g == G_ZOOM_IN) || (g == G_ZOOM_OUT);
  endfunction

endpackage

// [hw/i2c_op_if.sv]
`timescale 1ns/1ps
interface i2c_op_if;
  import touch_pkg::*;
  logic       req;
  op_t        op;
  logic [7:0] wdata;
  logic       last;
  logic       ready;
  logic       done;
  logic [7:0] rdata;
  logic       ack_ok;

  modport ctrl   (output req, op, wdata, last, input ready, done, rdata, ack_ok);
  modport engine (input req, op, wdata, last, output ready, done, rdata, ack_ok);
endinterface

// [hw/i2c_byte_engine.sv]
`timescale 1ns/1ps
module i2c_byte_engine import touch_pkg::*; #(
  parameter int QTR_CYCLES = QTR_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // operations
  i2c_op_if.engine  bus,
  // line side, sda_in already synchronised
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);

  // high-phase check below needs five or more cycles a quarter
  localparam int             TW     = $clog2(QTR_CYCLES);
  localparam logic [TW-1:0]  QTR_M1 = TW'(QTR_CYCLES - 1);

  typedef enum logic [3:0] {
    E_IDLE  = 4'b0001,
    E_START = 4'b0010,
    E_BYTE  = 4'b0100,
    E_STOP  = 4'b1000
  } estate_t;

  estate_t        state, next_state;
  logic [TW-1:0]  timer, next_timer;
  logic [1:0]     quarter, next_quarter;
  logic [3:0]     slot, next_slot;
  logic [8:0]     tx, next_tx;
  logic [8:0]     rx, next_rx;
  logic           done, next_done;
  logic           next_scl, next_sda_low;
  logic           tick;

  assign tick       = (timer == '0);
  assign bus.ready  = (state == E_IDLE);
  assign bus.done   = done;
  assign bus.rdata  = rx[8:1];
  assign bus.ack_ok = ~rx[0];

  // ==========================================================
  // next state
  always_comb begin
    next_state   = state;
    next_timer   = (state == E_IDLE) ? QTR_M1 : (tick ? QTR_M1 : timer - 1'b1);
    next_quarter = quarter;
    next_slot    = slot;
    next_tx      = tx;
    next_rx      = rx;
    next_done    = 1'b0;
    next_scl     = scl;
    next_sda_low = sda_low;
    unique case (state)
      E_IDLE: begin
        next_quarter = 2'h0;
        next_slot    = 4'h0;
        if (bus.req) begin
          unique case (bus.op)
            OP_START: next_state = E_START;
            OP_STOP:  next_state = E_STOP;
            OP_WRITE: begin
              next_state = E_BYTE;
              next_tx    = {bus.wdata, 1'b1};
            end
            OP_READ: begin
              next_state = E_BYTE;
              next_tx    = {8'hFF, bus.last}; // released bits, ack unless last
            end
          endcase
        end
      end
      E_START: begin
        next_scl     = quarter[0] ^ quarter[1];
        next_sda_low = quarter[1];
      end
      E_STOP: begin
        next_scl     = (quarter != 2'h0);
        next_sda_low = ~quarter[1];
      end
      E_BYTE: begin
        next_scl     = quarter[0] ^ quarter[1];
        next_sda_low = ~tx[8];
        if (tick && quarter == 2'h2) begin
          next_rx = {rx[7:0], sda_in};
        end
      end
    endcase
    if (state != E_IDLE && tick) begin
      next_quarter = quarter + 2'h1;
      if (quarter == 2'h3) begin
        if (state == E_BYTE) begin
          next_tx   = {tx[7:0], 1'b1};
          next_slot = slot + 4'h1;
        end
        if (state != E_BYTE || slot == 4'h8) begin
          next_state = E_IDLE;
          next_done  = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= E_IDLE;
      timer   <= QTR_M1;
      quarter <= 2'h0;
      slot    <= 4'h0;
      tx      <= 9'h1FF;
      rx      <= 9'h000;
      done    <= 1'b0;
      scl     <= 1'b1;
      sda_low <= 1'b0;
    end else begin
      state   <= next_state;
      timer   <= next_timer;
      quarter <= next_quarter;
      slot    <= next_slot;
      tx      <= next_tx;
      rx      <= next_rx;
      done    <= next_done;
      scl     <= next_scl;
      sda_low <= next_sda_low;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_SDA_STILL_WHILE_SCL_HIGH: assert property (
    (state == E_BYTE && scl && $past(scl)) |-> $stable(sda_low))
    else $error("data line moved while serial clock high");

  AST_SCL_HIGH_MIN: assert property (
    ($rose(scl) && state == E_BYTE) |=> scl [*8])
    else $error("serial clock high phase too short");

endmodule // i2c_byte_engine

// [hw/touch_gesture_reader.sv]
`timescale 1ns/1ps
module touch_gesture_reader import touch_pkg::*; #(
  parameter logic [6:0] TOUCH_ADDR = 7'h38,
  parameter int         QTR_CYCLES = QTR_CYC
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // touch controller interrupt, active low
  input  wire logic              TOUCH_IRQ_IN_N,
  // results
  output logic                   RESULT_VALID_OUT,
  output logic [X_W-1:0]         POINT1_X,
  output logic [Y_W-1:0]         POINT1_Y,
  output logic [X_W-1:0]         POINT2_X,
  output logic [Y_W-1:0]         POINT2_Y,
  output logic [CNT_W-1:0]       ACTIVE_TOUCH_COUNT,
  output logic [GEST_W-1:0]      GESTURE_CODE,
  // serial link
  output logic                   SERIAL_CLOCK_OUT,
  input  wire logic              SERIAL_DATA_IO_IN,
  output logic                   SERIAL_DATA_IO_OUT,
  output logic                   SERIAL_DATA_IO_OE
);

  typedef enum logic [9:0] {
    S_IDLE     = 10'b0000000001,
    S_START    = 10'b0000000010,
    S_WADDR    = 10'b0000000100,
    S_WREG     = 10'b0000001000,
    S_RSTART   = 10'b0000010000,
    S_RADDR    = 10'b0000100000,
    S_RDATA    = 10'b0001000000,
    S_STOP     = 10'b0010000000,
    S_PUBLISH  = 10'b0100000000,
    S_ANNOUNCE = 10'b1000000000
  } state_t;

  i2c_op_if bus ();

  state_t             state, next_state;
  logic               sent, next_sent;
  logic               fail, next_fail;
  logic [3:0]         idx, next_idx;
  logic [7:0]         buffer [READ_LEN];
  logic [7:0]         next_buffer [READ_LEN];
  logic               valid, next_valid;
  logic [X_W-1:0]     point1_x, next_point1_x;
  logic [Y_W-1:0]     point1_y, next_point1_y;
  logic [X_W-1:0]     point2_x, next_point2_x;
  logic [Y_W-1:0]     point2_y, next_point2_y;
  logic [CNT_W-1:0]   count, next_count;
  logic [GEST_W-1:0]  gesture, next_gesture;
  logic               irq_meta, irq_sync, irq_prev;
  logic               sda_meta, sda_sync;
  logic               irq_fall;
  logic               scl, sda_low;
  logic               last_byte;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
      irq_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      irq_meta <= TOUCH_IRQ_IN_N;
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
      sda_meta <= SERIAL_DATA_IO_IN;
      sda_sync <= sda_meta;
    end
  end

  // edge, not level: a line held low after a read must not loop
  assign irq_fall = irq_prev & ~irq_sync;

  // ==========================================================
  // byte engine
  i2c_byte_engine #(.QTR_CYCLES(QTR_CYCLES)) engine (
    .clk     (CLK),
    .reset   (RESET),
    .bus     (bus.engine),
    .sda_in  (sda_sync),
    .scl     (scl),
    .sda_low (sda_low)
  );

  assign SERIAL_CLOCK_OUT   = scl;
  assign SERIAL_DATA_IO_OUT = 1'b0;
  assign SERIAL_DATA_IO_OE  = sda_low;

  assign last_byte = (idx == 4'(READ_LEN - 1));

  // ==========================================================
  // operation requests
  always_comb begin
    bus.req   = 1'b0;
    bus.op    = OP_START;
    bus.wdata = 8'h00;
    bus.last  = last_byte;
    unique case (state)
      S_START, S_RSTART: begin
        bus.req = ~sent;
        bus.op  = OP_START;
      end
      S_WADDR: begin
        bus.req   = ~sent;
        bus.op    = OP_WRITE;
        bus.wdata = {TOUCH_ADDR, 1'b0};
      end
      S_WREG: begin
        bus.req   = ~sent;
        bus.op    = OP_WRITE;
        bus.wdata = REG_FIRST;
      end
      S_RADDR: begin
        bus.req   = ~sent;
        bus.op    = OP_WRITE;
        bus.wdata = {TOUCH_ADDR, 1'b1};
      end
      S_RDATA: begin
        bus.req = ~sent;
        bus.op  = OP_READ;
      end
      S_STOP: begin
        bus.req = ~sent;
        bus.op  = OP_STOP;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // sequencer and results
  always_comb begin
    next_state    = state;
    next_sent     = sent;
    next_fail     = fail;
    next_idx      = idx;
    next_buffer   = buffer;
    next_valid    = valid;
    next_point1_x = point1_x;
    next_point1_y = point1_y;
    next_point2_x = point2_x;
    next_point2_y = point2_y;
    next_count    = count;
    next_gesture  = gesture;
    if (bus.req && bus.ready) begin
      next_sent = 1'b1;
    end
    if (bus.done) begin
      next_sent = 1'b0;
    end
    unique case (state)
      S_IDLE: begin
        if (irq_fall) begin
          next_state = S_START;
          next_valid = 1'b0;
          next_fail  = 1'b0;
          next_idx   = 4'h0;
        end
      end
      S_START: if (bus.done) next_state = S_WADDR;
      S_WADDR: begin
        if (bus.done) begin
          next_state = bus.ack_ok ? S_WREG : S_STOP;
          next_fail  = ~bus.ack_ok;
        end
      end
      S_WREG: begin
        if (bus.done) begin
          next_state = bus.ack_ok ? S_RSTART : S_STOP;
          next_fail  = ~bus.ack_ok;
        end
      end
      S_RSTART: if (bus.done) next_state = S_RADDR;
      S_RADDR: begin
        if (bus.done) begin
          next_state = bus.ack_ok ? S_RDATA : S_STOP;
          next_fail  = ~bus.ack_ok;
        end
      end
      S_RDATA: begin
        if (bus.done) begin
          next_buffer[idx] = bus.rdata;
          next_idx         = idx + 4'h1;
          if (last_byte) begin
            next_state = S_STOP;
          end
        end
      end
      S_STOP: begin
        if (bus.done) begin
          // a refused read leaves the previous results and keeps valid low
          next_state = fail ? S_IDLE : S_PUBLISH;
        end
      end
      S_PUBLISH: begin
        next_point1_x = {buffer[B_X1_HI][1:0], buffer[B_X1_LO]};
        next_point2_x = {buffer[B_X2_HI][1:0], buffer[B_X2_LO]};
        next_point1_y = {buffer[B_Y1_HI][0], buffer[B_Y1_LO]};
        next_point2_y = {buffer[B_Y2_HI][0], buffer[B_Y2_LO]};
        next_count    = (buffer[B_COUNT] > 8'(COUNT_MAX)) ? COUNT_MAX : buffer[B_COUNT][1:0];
        next_gesture  = gesture_known(buffer[B_GESTURE]) ? buffer[B_GESTURE] : G_NONE;
        next_state    = S_ANNOUNCE;
      end
      S_ANNOUNCE: begin
        next_valid = 1'b1;
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state    <= S_IDLE;
      sent     <= 1'b0;
      fail     <= 1'b0;
      idx      <= 4'h0;
      valid    <= 1'b0;
      point1_x <= X_RST;
      point1_y <= Y_RST;
      point2_x <= X_RST;
      point2_y <= Y_RST;
      count    <= CNT_RST;
      gesture  <= G_NONE;
      for (int i = 0; i < READ_LEN; i++) begin
        buffer[i] <= 8'h00;
      end
    end else begin
      state    <= next_state;
      sent     <= next_sent;
      fail     <= next_fail;
      idx      <= next_idx;
      valid    <= next_valid;
      point1_x <= next_point1_x;
      point1_y <= next_point1_y;
      point2_x <= next_point2_x;
      point2_y <= next_point2_y;
      count    <= next_count;
      gesture  <= next_gesture;
      buffer   <= next_buffer;
    end
  end

  assign RESULT_VALID_OUT   = valid;
  assign POINT1_X           = point1_x;
  assign POINT1_Y           = point1_y;
  assign POINT2_X           = point2_x;
  assign POINT2_Y           = point2_y;
  assign ACTIVE_TOUCH_COUNT = count;
  assign GESTURE_CODE       = gesture;

  // ==========================================================
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_VALID_AFTER_LOAD: assert property (
    (state == S_PUBLISH) |=> (!valid ##1 $rose(valid)))
    else $error("valid did not rise one cycle after results loaded");

  AST_VALID_DROPS_ON_READ: assert property (
    (state == S_IDLE && irq_fall) |=> (!valid && state == S_START))
    else $error("read start did not drop valid");

  AST_RESULTS_HELD: assert property (
    (state != S_PUBLISH) |=> $stable({point1_x, point1_y, point2_x, point2_y, count, gesture}))
    else $error("results changed outside a load");

  AST_COUNT_LEGAL: assert property (
    count <= COUNT_MAX)
    else $error("touch count above two");

  AST_GESTURE_DEFINED: assert property (
    gesture_known(gesture) || gesture == G_NONE)
    else $error("undefined gesture code shown");

  AST_NACK_ENDS_READ: assert property (
    (state == S_WADDR && bus.done && !bus.ack_ok) |=> (state == S_STOP && fail))
    else $error("refused address did not stop the read");

  AST_FAIL_NO_PUBLISH: assert property (
    (state == S_STOP && bus.done && fail) |=> (state == S_IDLE && !valid))
    else $error("failed read published results");

  AST_OPEN_DRAIN: assert property (
    (state == S_IDLE) |-> (!SERIAL_DATA_IO_OE && SERIAL_CLOCK_OUT && SERIAL_DATA_IO_OUT == 1'b0))
    else $error("serial lines not released while idle");

endmodule // touch_gesture_reader

// [testbench/touch_ctrl_model.sv]
`timescale 1ns/1ps
module touch_ctrl_model (
  // serial link
  input  wire logic        scl,
  input  wire logic        sda,
  output logic             sda_low,
  // scenario controls
  input  wire logic        nack_addr,
  input  wire logic [79:0] tx_bytes
);
  // ==========================================================
  // state
  logic [7:0] rx [$];
  logic [7:0] sh;
  int         bitcnt;
  int         idx;
  int         acks;
  int         nacks;
  logic       active;
  logic       rd;
  logic       first;
  logic       rd_next;

  initial begin
    rd_next = 1'b0;
    sda_low = 1'b0;
    active  = 1'b0;
    rd      = 1'b0;
    first   = 1'b0;
    bitcnt  = 0;
    idx     = 0;
    acks    = 0;
    nacks   = 0;
  end

  // ==========================================================
  // framing
  // the clock fall that closes a start is not a data bit
  always @(negedge sda) if (scl) begin
    active  = 1'b1;
    first   = 1'b1;
    rd      = 1'b0;
    rd_next = 1'b0;
    bitcnt  = -1;
    idx     = 0;
    sda_low = 1'b0;
  end

  always @(posedge sda) if (scl) begin
    active  = 1'b0;
    sda_low = 1'b0;
  end

  // ==========================================================
  // bits
  always @(posedge scl) if (active) begin
    if (bitcnt < 8) begin
      sh = {sh[6:0], sda};
    end else if (rd) begin
      // controller answers each read byte; a high level ends our driving
      if (sda) nacks++;
      else acks++;
      if (sda) rd = 1'b0;
      idx++;
    end
  end

  // no clock stretching, so every change lands while the clock is low
  always @(negedge scl) if (active) begin
    if (bitcnt == 7) begin
      bitcnt  = 8;
      sda_low = 1'b0;
      if (!rd) begin
        rx.push_back(sh);
        sda_low = !(first && nack_addr);
        rd_next = first && sh[0];
        first   = 1'b0;
      end
    end else if (bitcnt == 8) begin
      bitcnt  = 0;
      if (rd_next) rd = 1'b1;
      rd_next = 1'b0;
      sda_low = rd && !tx_bytes[79 - 8*idx];
    end else begin
      bitcnt++;
      sda_low = rd && !tx_bytes[79 - 8*idx - bitcnt];
    end
  end
endmodule // touch_ctrl_model

// [testbench/tb_touch_gesture_reader.sv]
`timescale 1ns/1ps
module tb_touch_gesture_reader import touch_pkg::*;;
  localparam logic [6:0] DEV_ADDR  = 7'h38;
  // short quarters keep a full read near five thousand cycles
  localparam int         BENCH_QTR = 10;
  localparam int         MID_CYC   = 2000;
  localparam int         READ_CYC  = 8000;
  localparam int         LIMIT_CYC = 40000;

  // ==========================================================
  // signals
  logic              clk = 1'b0;
  logic              reset;
  logic              irq_n;
  logic              valid;
  logic [X_W-1:0]    p1x;
  logic [Y_W-1:0]    p1y;
  logic [X_W-1:0]    p2x;
  logic [Y_W-1:0]    p2y;
  logic [CNT_W-1:0]  cnt;
  logic [GEST_W-1:0] gest;
  logic              scl;
  logic              data_out;
  logic              oe;
  logic              sda_low;
  logic              sda_line;
  logic              nack_addr;
  logic [79:0]       tx_bytes;
  logic [15:0]       ex1 = 16'h0000;
  logic [15:0]       ey1 = 16'h0000;
  logic [15:0]       ex2 = 16'h0000;
  logic [15:0]       ey2 = 16'h0000;
  logic [15:0]       ecnt = 16'h0000;
  logic [15:0]       eg = 16'h0000;
  int                err_count = 0;
  int                n_checks = 0;

  always #2.5 clk = ~clk;

  // released line reads the pull-up, never the last driven bit
  assign sda_line = oe ? data_out : (sda_low ? 1'b0 : 1'b1);

  touch_gesture_reader #(.TOUCH_ADDR(DEV_ADDR), .QTR_CYCLES(BENCH_QTR)) touch_gesture_reader_i (
    .CLK                (clk),
    .RESET              (reset),
    .TOUCH_IRQ_IN_N     (irq_n),
    .RESULT_VALID_OUT   (valid),
    .POINT1_X           (p1x),
    .POINT1_Y           (p1y),
    .POINT2_X           (p2x),
    .POINT2_Y           (p2y),
    .ACTIVE_TOUCH_COUNT (cnt),
    .GESTURE_CODE       (gest),
    .SERIAL_CLOCK_OUT   (scl),
    .SERIAL_DATA_IO_IN  (sda_line),
    .SERIAL_DATA_IO_OUT (data_out),
    .SERIAL_DATA_IO_OE  (oe)
  );

  touch_ctrl_model touch_ctrl_model_i (
    .scl       (scl),
    .sda       (sda_line),
    .sda_low   (sda_low),
    .nack_addr (nack_addr),
    .tx_bytes  (tx_bytes)
  );

  // ==========================================================
  // helpers
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_results();
    check_val(16'(p1x), ex1);
    check_val(16'(p1y), ey1);
    check_val(16'(p2x), ex2);
    check_val(16'(p2y), ey2);
    check_val(16'(cnt), ecnt);
    check_val(16'(gest), eg);
  endtask

  task automatic fire_irq();
    @(negedge clk);
    irq_n = 1'b0;
    repeat (20) @(negedge clk);
    irq_n = 1'b1;
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // full read; coordinates follow the byte layout, high spare bits ignored
  task automatic do_read(input logic [79:0] bytes, input logic [7:0] g_exp, input logic [1:0] c_exp);
    int cyc;
    cyc = 0;
    tx_bytes = bytes;
    touch_ctrl_model_i.rx.delete();
    touch_ctrl_model_i.acks = 0;
    touch_ctrl_model_i.nacks = 0;
    fire_irq();
    check_val(16'(valid), 16'h0000);
    repeat (MID_CYC) @(negedge clk);
    check_val(16'(valid), 16'h0000);
    check_results();
    while (valid !== 1'b1 && cyc < READ_CYC) begin
      @(negedge clk);
      cyc++;
    end
    check_val(16'(valid), 16'h0001);
    ex1  = 16'(bytes[57:48]);
    ey1  = 16'(bytes[40:32]);
    ex2  = 16'(bytes[25:16]);
    ey2  = 16'(bytes[8:0]);
    ecnt = 16'(c_exp);
    eg   = 16'(g_exp);
    check_results();
    check_val(16'(touch_ctrl_model_i.rx.size()), 16'h0003);
    check_val(16'(touch_ctrl_model_i.rx[0]), 16'({DEV_ADDR, 1'b0}));
    check_val(16'(touch_ctrl_model_i.rx[1]), 16'(REG_FIRST));
    check_val(16'(touch_ctrl_model_i.rx[2]), 16'({DEV_ADDR, 1'b1}));
    check_val(16'(touch_ctrl_model_i.acks), 16'h0009);
    check_val(16'(touch_ctrl_model_i.nacks), 16'h0001);
    check_val(16'({scl, oe, data_out}), 16'h0004);
    repeat (50) @(negedge clk);
    check_results();
  endtask

  // ==========================================================
  // scenarios
  task automatic read_two_point_zoom();
    do_read(80'h48_02_FF_FF_FF_FF_FE_34_00_23, 8'h48, 2'h2);
  endtask

  // an unknown gesture shows as no gesture with the first point intact
  task automatic read_unknown_clamped();
    do_read(80'h11_05_01_00_00_80_00_00_01_FF, 8'h00, 2'h2);
  endtask

  task automatic read_refused();
    nack_addr = 1'b1;
    touch_ctrl_model_i.rx.delete();
    fire_irq();
    check_val(16'(valid), 16'h0000);
    repeat (MID_CYC) @(negedge clk);
    check_val(16'(valid), 16'h0000);
    check_results();
    check_val(16'(touch_ctrl_model_i.rx.size()), 16'h0001);
    check_val(16'({scl, oe}), 16'h0002);
    nack_addr = 1'b0;
  endtask

  task automatic read_one_point_move();
    do_read(80'h1E_01_00_05_00_06_00_00_00_00, 8'h1E, 2'h1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    irq_n = 1'b1;
    nack_addr = 1'b0;
    tx_bytes = 80'h0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check_results();
    check_val(16'({valid, scl, oe}), 16'h0002);
    read_two_point_zoom();
    read_unknown_clamped();
    read_refused();
    read_one_point_move();
    final_report();
  end

  // all scenarios finish in under twenty thousand cycles
  initial begin
    repeat (LIMIT_CYC) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule // tb_touch_gesture_reader
